//--- rtl/adc_channel_setup_gain_regs.sv
// Summary of operation
// - Setup bit 7 powers up left ADC; resets to 0.
// - Setup bit 6 powers up right ADC; resets to 0.
// - Setup bits 5:4 pick microphone pin: GPIO, bit clock, data in; 11 forbidden.
// - Setup bit 3 routes left ADC from digital microphone.
// - Setup bit 2 routes right ADC from digital microphone.
// - Setup bits 1:0 soft-step rate: per word clock, per two, immediate.
// - Fine gain bit 7 mutes left ADC; resets muted.
// - Fine gain bits 6:4 left fine gain 0 to -0.4dB; 001-011 forbidden.
// - Fine gain bit 3 mutes right ADC; resets muted.
// - Fine gain bits 2:0 right fine gain, same codes as left.
// - Left volume bits 6:0 two's complement half-dB steps, -12 to +20dB.
// - Left volume bit 7 reserved, reads 0, written as 0.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_setup_gain_regs
    import adc_setup_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              write_i,
    input  wire logic              read_i,
    input  wire logic              word_clk_i,
    output logic [DATA_W-1:0]      rdata_o,
    output adc_ctrl_t              ctrl_o
);

    typedef struct packed {
        channel_setup_t   setup;
        fine_gain_t       fine;
        logic [VOL_W-1:0] left_vol;
        logic [DATA_W-1:0] rdata;
        logic             wclk_meta;
        logic             wclk_sync;
        logic             wclk_prev;
        adc_ctrl_t        ctrl;
    } regs_state_t;

    regs_state_t s_q;
    regs_state_t s_d;

    logic             word_tick;
    logic [VOL_W-1:0] vol_applied;
    logic             vol_settled;

    assign word_tick = s_q.wclk_sync & ~s_q.wclk_prev;

    vol_stepper #(
        .W (VOL_W)
    ) u_vol_stepper (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .word_tick_i (word_tick),
        .mode_i      (s_q.setup.step_mode),
        .target_i    (s_q.left_vol),
        .applied_o   (vol_applied),
        .settled_o   (vol_settled)
    );

    always_comb begin
        s_d = s_q;
        s_d.wclk_meta = word_clk_i;
        s_d.wclk_sync = s_q.wclk_meta;
        s_d.wclk_prev = s_q.wclk_sync;
        if (write_i) begin
            unique case (addr_i)
                ADC_CHANNEL_SETUP_OFS: begin
                    s_d.setup = channel_setup_t'(wdata_i);
                end
                ADC_FINE_GAIN_MUTE_OFS: begin
                    s_d.fine = fine_gain_t'(wdata_i);
                end
                LEFT_ADC_VOLUME_OFS: begin
                    s_d.left_vol = wdata_i[VOL_W-1:0];
                end
                default: begin
                end
            endcase
        end
        s_d.rdata = '0;
        if (read_i) begin
            unique case (addr_i)
                ADC_CHANNEL_SETUP_OFS: begin
                    s_d.rdata = s_q.setup;
                end
                ADC_FINE_GAIN_MUTE_OFS: begin
                    s_d.rdata = s_q.fine;
                end
                LEFT_ADC_VOLUME_OFS: begin
                    s_d.rdata = {1'b0, s_q.left_vol};
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
        s_d.ctrl.left_power   = s_q.setup.left_power;
        s_d.ctrl.right_power  = s_q.setup.right_power;
        s_d.ctrl.left_dmic    = s_q.setup.left_dmic;
        s_d.ctrl.right_dmic   = s_q.setup.right_dmic;
        s_d.ctrl.dmic_on_gpio = s_q.setup.dmic_sel == DMIC_GPIO;
        s_d.ctrl.dmic_on_bclk = s_q.setup.dmic_sel == DMIC_BCLK;
        s_d.ctrl.dmic_on_din  = s_q.setup.dmic_sel == DMIC_DIN;
        s_d.ctrl.left_mute    = s_q.fine.left_mute;
        s_d.ctrl.right_mute   = s_q.fine.right_mute;
        s_d.ctrl.left_fine    = s_q.fine.left_fine;
        s_d.ctrl.right_fine   = s_q.fine.right_fine;
        s_d.ctrl.left_vol_applied = vol_applied;
        s_d.ctrl.left_vol_settled = vol_settled;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q          <= '0;
            s_q.setup    <= channel_setup_t'(ADC_CHANNEL_SETUP_RST);
            s_q.fine     <= fine_gain_t'(ADC_FINE_GAIN_MUTE_RST);
            s_q.left_vol <= LEFT_ADC_VOLUME_RST;
            s_q.ctrl.left_mute  <= 1'b1;
            s_q.ctrl.right_mute <= 1'b1;
            s_q.ctrl.dmic_on_gpio <= 1'b1;
            s_q.ctrl.left_vol_settled <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign ctrl_o  = s_q.ctrl;

endmodule
`default_nettype wire

//--- rtl/adc_setup_pkg.sv
package adc_setup_pkg;

    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 8;
    localparam int          VOL_W               = 7;

    localparam logic [7:0]  ADC_CHANNEL_SETUP_OFS  = 8'h51;
    localparam logic [7:0]  ADC_FINE_GAIN_MUTE_OFS = 8'h52;
    localparam logic [7:0]  LEFT_ADC_VOLUME_OFS    = 8'h53;

    localparam logic [7:0]  ADC_CHANNEL_SETUP_RST  = 8'h00;
    localparam logic [7:0]  ADC_FINE_GAIN_MUTE_RST = 8'h88;
    localparam logic [6:0]  LEFT_ADC_VOLUME_RST    = 7'h00;

    localparam int          LEFT_PWR_BIT        = 7;
    localparam int          RIGHT_PWR_BIT       = 6;
    localparam int          DMIC_SEL_HI         = 5;
    localparam int          DMIC_SEL_LO         = 4;
    localparam int          LEFT_DMIC_BIT       = 3;
    localparam int          RIGHT_DMIC_BIT      = 2;
    localparam int          STEP_HI             = 1;
    localparam int          STEP_LO             = 0;
    localparam int          LEFT_MUTE_BIT       = 7;
    localparam int          LEFT_FINE_HI        = 6;
    localparam int          LEFT_FINE_LO        = 4;
    localparam int          RIGHT_MUTE_BIT      = 3;
    localparam int          RIGHT_FINE_HI       = 2;
    localparam int          RIGHT_FINE_LO       = 0;

    localparam logic [6:0]  VOL_MIN             = 7'h68;
    localparam logic [6:0]  VOL_MAX             = 7'h28;

    typedef enum logic [1:0] {
        DMIC_GPIO       = 2'b00,
        DMIC_BCLK       = 2'b01,
        DMIC_DIN        = 2'b10,
        DMIC_RESERVED   = 2'b11
    } dmic_sel_t;

    typedef enum logic [1:0] {
        STEP_EVERY_WCLK = 2'b00,
        STEP_EVERY_TWO  = 2'b01,
        STEP_DISABLED   = 2'b10,
        STEP_RESERVED   = 2'b11
    } step_mode_t;

    typedef struct packed {
        logic       left_power;
        logic       right_power;
        dmic_sel_t  dmic_sel;
        logic       left_dmic;
        logic       right_dmic;
        step_mode_t step_mode;
    } channel_setup_t;

    typedef struct packed {
        logic       left_mute;
        logic [2:0] left_fine;
        logic       right_mute;
        logic [2:0] right_fine;
    } fine_gain_t;

    typedef struct packed {
        logic            left_power;
        logic            right_power;
        logic            left_dmic;
        logic            right_dmic;
        logic            dmic_on_gpio;
        logic            dmic_on_bclk;
        logic            dmic_on_din;
        logic            left_mute;
        logic            right_mute;
        logic [2:0]      left_fine;
        logic [2:0]      right_fine;
        logic [VOL_W-1:0] left_vol_applied;
        logic            left_vol_settled;
    } adc_ctrl_t;

endpackage

//--- rtl/vol_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module vol_stepper
    import adc_setup_pkg::*;
#(
    parameter int W = VOL_W
) (
    input  wire logic         clock_i,
    input  wire logic         reset_n_i,
    input  wire logic         word_tick_i,
    input  wire step_mode_t   mode_i,
    input  wire logic [W-1:0] target_i,
    output logic [W-1:0]      applied_o,
    output logic              settled_o
);

    typedef struct packed {
        logic [W-1:0] applied;
        logic         half;
    } step_state_t;

    step_state_t s_q;
    step_state_t s_d;

    // Elaboration check: a step needs at least a sign bit and one magnitude bit
    if (W < 2) begin : g_width_check
        $error("vol_stepper width too small");
    end

    always_comb begin
        s_d = s_q;
        if (mode_i == STEP_DISABLED || mode_i == STEP_RESERVED) begin
            s_d.applied = target_i;
            s_d.half    = 1'b0;
        end else if (word_tick_i && s_q.applied != target_i) begin
            s_d.half = ~s_q.half;
            if (mode_i == STEP_EVERY_WCLK || s_q.half) begin
                if ($signed(target_i) > $signed(s_q.applied)) begin
                    s_d.applied = W'(s_q.applied + 1'b1);
                end else begin
                    s_d.applied = W'(s_q.applied - 1'b1);
                end
            end
        end else if (s_q.applied == target_i) begin
            s_d.half = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign applied_o = s_q.applied;
    assign settled_o = (s_q.applied == target_i);

endmodule
`default_nettype wire

//--- verif/adc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adc_regs_chk
    import adc_setup_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       write_i,
    input wire logic       read_i,
    input wire logic       word_clk_i,
    input wire logic [7:0] rdata_o,
    input wire adc_ctrl_t  ctrl_o
);
    logic w1, w2, imm_q;
    assign w1 = write_i && addr_i == 8'h51;
    assign w2 = write_i && addr_i == 8'h52;
    // Immediate volume mode as last written
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i)
            imm_q <= 1'b0;
        else if (w1)
            imm_q <= wdata_i[1];
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    lpwr_a: assert property
        (w1 |-> ##2 ctrl_o.left_power == $past(wdata_i[7], 2))
        else $error("left power");
    rpwr_a: assert property
        (w1 |-> ##2 ctrl_o.right_power == $past(wdata_i[6], 2))
        else $error("right power");
    dsel_a: assert property
        (w1 |-> ##2 {ctrl_o.dmic_on_din, ctrl_o.dmic_on_bclk,
            ctrl_o.dmic_on_gpio} == 3'(3'h1 << $past(wdata_i[5:4], 2)))
        else $error("mic pin select");
    dmic_a: assert property
        (w1 |-> ##2 {ctrl_o.left_dmic, ctrl_o.right_dmic}
            == $past(wdata_i[3:2], 2))
        else $error("mic routing");
    mute_a: assert property
        (w2 |-> ##2 {ctrl_o.left_mute, ctrl_o.right_mute}
            == {$past(wdata_i[7], 2), $past(wdata_i[3], 2)})
        else $error("mute");
    fine_a: assert property
        (w2 |-> ##2 {ctrl_o.left_fine, ctrl_o.right_fine}
            == {$past(wdata_i[6:4], 2), $past(wdata_i[2:0], 2)})
        else $error("fine gain");
    rsv_bit_a: assert property
        (read_i && addr_i == 8'h53 |=> rdata_o[7] == 1'b0)
        else $error("reserved bit");
    one_step_a: assert property
        (!imm_q && $changed(ctrl_o.left_vol_applied) |->
            7'(ctrl_o.left_vol_applied - $past(ctrl_o.left_vol_applied))
            inside {7'h01, 7'h7F})
        else $error("volume step");
    cover property (!imm_q && $changed(ctrl_o.left_vol_applied));
    cover property (w1 && wdata_i[5:4] == 2'b10);
    cover property (read_i && addr_i == 8'h53);
endmodule
bind adc_channel_setup_gain_regs adc_regs_chk u_chk (.*);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adc_setup_pkg::*;
;
    logic       clock_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       write_i = 1'b0;
    logic       read_i = 1'b0;
    logic       word_clk_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    adc_ctrl_t  ctrl_o;
    int         err_count = 0;
    int         n_checks = 0;
    int         k;
    logic [7:0] d;
    logic [6:0] cur;
    logic [2:0] fc [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    adc_channel_setup_gain_regs u_dut (
        .clock_i    (clock_i),
        .reset_n_i  (reset_n_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .write_i    (write_i),
        .read_i     (read_i),
        .word_clk_i (word_clk_i),
        .rdata_o    (rdata_o),
        .ctrl_o     (ctrl_o)
    );
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    task automatic cmp(input string n, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, x);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= x;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, input string n);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 cmp(n, e, rdata_o);
    endtask
    task automatic tick();
        word_clk_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        word_clk_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
    endtask
    // One tick per step toward the target
    task automatic walk(input logic [6:0] t, input int n);
        wr(8'h53, {1'b0, t});
        repeat (n) begin
            tick();
            if (cur != t)
                cur = $signed(t) > $signed(cur) ? cur + 7'h01 : cur - 7'h01;
            cmp("step", {1'b0, cur}, {1'b0, ctrl_o.left_vol_applied});
        end
    endtask
    function automatic logic [2:0] hot(input logic [1:0] c);
        return 3'(3'h1 << c);
    endfunction
    initial begin
        void'($urandom(32'h5A04));
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        cmp("ctl rst", 8'h0F, {2'b00, ctrl_o.left_power, ctrl_o.right_power,
            ctrl_o.left_mute, ctrl_o.right_mute, ctrl_o.dmic_on_gpio,
            ctrl_o.left_vol_settled});
        rd(8'h51, 8'h00, "setup rst");
        rd(8'h52, 8'h88, "fine rst");
        rd(8'h53, 8'h00, "vol rst");
        @(posedge clock_i);
        #1 cmp("rd idle", 8'h00, rdata_o);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            d = (8'($urandom) & 8'hCC) | {2'h0, 2'(i / 3), 2'h0, 2'(i % 3)};
            wr(8'h51, d);
            @(posedge clock_i);
            #1 cmp("ctl", {d[7:6], d[3:2], 1'b0, hot(d[5:4])},
                {ctrl_o.left_power, ctrl_o.right_power, ctrl_o.left_dmic,
                ctrl_o.right_dmic, 1'b0, ctrl_o.dmic_on_din,
                ctrl_o.dmic_on_bclk, ctrl_o.dmic_on_gpio});
            rd(8'h51, d, "setup");
        end
        $display("setup test done");
        for (int i = 0; i < 5; i++) begin
            d = {1'($urandom), fc[i], 1'($urandom), fc[4 - i]};
            wr(8'h52, d);
            @(posedge clock_i);
            #1 cmp("fine", d, {ctrl_o.left_mute, ctrl_o.left_fine,
                ctrl_o.right_mute, ctrl_o.right_fine});
            rd(8'h52, d, "fine rd");
        end
        wr(8'h54, 8'hFF);
        rd(8'h54, 8'h00, "unmapped");
        rd(8'h52, d, "kept");
        $display("gain test done");
        wr(8'h51, 8'h02);
        for (int i = 0; i < 6; i++) begin
            cur = i == 0 ? VOL_MIN : i == 1 ? VOL_MAX : i == 5 ? 7'h00
                : 7'($urandom_range(64) - 24);
            wr(8'h53, {1'b0, cur});
            repeat (3) @(posedge clock_i);
            #1 cmp("vol", {1'b0, cur}, {1'b0, ctrl_o.left_vol_applied});
            rd(8'h53, {1'b0, cur}, "vol rd");
        end
        $display("volume test done");
        wr(8'h51, 8'h00);
        walk(7'h03, 4);
        walk(7'h7E, 5);
        cmp("settled", 8'h01, {7'h00, ctrl_o.left_vol_settled});
        wr(8'h51, 8'h01);
        wr(8'h53, 8'h04);
        repeat (3) @(posedge clock_i);
        for (k = 0; k < 20 && ctrl_o.left_vol_settled !== 1'b1; k++)
            tick();
        if (k == 20) begin
            err_count++;
            report_and_stop();
        end
        cmp("slow", 8'h01, 8'(k >= 11 && k <= 12));
        cmp("slow vol", 8'h04, {1'b0, ctrl_o.left_vol_applied});
        $display("stepping test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
